// >>> rtl/isa_pkg.sv
// constants, register map and carrier types of the interrupt/status aggregator
`default_nettype none
package isa_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned REFRESH_PERIOD_NS = 1_000_000;
  localparam int unsigned REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // register indices on the register port
  localparam logic [3:0] IDX_FLAGS_FIRST = 4'h0;
  localparam logic [3:0] IDX_FLAGS_SECOND = 4'h1;
  localparam logic [3:0] IDX_FLAGS_THIRD = 4'h2;
  localparam logic [3:0] IDX_FLAGS_FOURTH = 4'h3;
  localparam logic [3:0] IDX_FAULT_FLAGS = 4'h4;
  localparam logic [3:0] IDX_ENABLE_FIRST = 4'h5;
  localparam logic [3:0] IDX_FAULT_ENABLE = 4'h9;
  localparam logic [3:0] IDX_ENERGY_PULSE_CFG = 4'hA;
  localparam logic [3:0] IDX_HALF_DIP_MIN = 4'hB;
  localparam logic [3:0] IDX_ONE_DIP_MIN = 4'hC;
  localparam logic [3:0] IDX_HALF_SWELL_MAX = 4'hD;
  localparam logic [3:0] IDX_ONE_SWELL_MAX = 4'hE;

  // ==========================================================================
  // bit positions
  localparam int unsigned BIT_ENERGY_READY = 0;
  localparam int unsigned BIT_SHARED_14 = 14;
  localparam int unsigned BIT_DIP_EVT = 0;
  localparam int unsigned BIT_SWELL_EVT = 1;
  localparam int unsigned BIT_INIT_FAIL = 0;
  localparam int unsigned BIT_CRC_FAIL = 6;
  localparam int unsigned BIT_RATE_FAULT = 8;
  localparam int unsigned BIT_CONV_BASE = 9;
  localparam int unsigned BIT_ENERGY_TIMER_SEL = 0;

  // converter status bits that feed a fault bit
  localparam logic [7:0] CONV_SEL_FIRST = 8'h3F;
  localparam logic [7:0] CONV_SEL_SECOND = 8'h0E;
  localparam logic [7:0] CONV_SEL_THIRD = 8'h7F;

  // ==========================================================================
  // reset values
  localparam logic [31:0] ENABLE_SECOND_RESET = 32'h0000_4000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [31:0] wdata;
  } isa_reg_req_t;

  typedef struct packed {
    logic [31:0] shared_evt;
    logic [31:0] third_evt;
    logic [31:0] fourth_evt;
    logic [23:0] rms_half;
    logic half_stb;
    logic [23:0] rms_one;
    logic one_stb;
    logic dip_half;
    logic swell_half;
    logic dip_one;
    logic swell_one;
    logic energy_line_stb;
    logic init_fail;
    logic [5:0] internal_fault;
    logic crc_fail;
    logic rate_fault;
    logic [23:0] sample;
    logic sample_stb;
  } isa_dp_in_t;

  typedef logic [3:0][2:0][7:0] isa_conv_stat_t;

endpackage
`default_nettype wire

// >>> rtl/isa_w1c_reg.sv
// one sticky write-one-to-clear flag register
`timescale 1ns/1ps
`default_nettype none

module isa_w1c_reg (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_in, // async reset, active high
  input wire logic [31:0] set_in, // hardware events, one per bit
  input wire logic [31:0] clr_in, // ones written by software
  output logic [31:0] flags_out // sticky flags
);
  import isa_pkg::*;

  typedef struct packed {
    logic [31:0] flags;
  } isa_w1c_st_t;

  isa_w1c_st_t state_ff;
  isa_w1c_st_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    // zeros written leave bits alone; a same-cycle event beats the clear
    nxt_state.flags = (state_ff.flags & ~clr_in) | set_in;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flags_out = state_ff.flags;

endmodule
`default_nettype wire

// >>> rtl/isa_status_top.sv
// status flags, masks, interrupt pins and refresh cadence of the metrology core
`timescale 1ns/1ps
`default_nettype none

module isa_status_top #(
  parameter int unsigned REFRESH_CYCLES = isa_pkg::REFRESH_CYCLES
) (
  input wire logic sys_clk_in, // 40 MHz system clock
  input wire logic reset_in, // async reset, active high
  input wire isa_pkg::isa_reg_req_t reg_req_in, // register write/address port
  output logic [31:0] reg_rdata_out, // read data of last cycle's address
  input wire isa_pkg::isa_dp_in_t dp_in, // events from the datapath
  input wire isa_pkg::isa_conv_stat_t conv_stat_in, // converter status copies
  input wire logic [31:0] meas_in, // live measurement word
  output logic [31:0] meas_out, // measurement refreshed every ms
  input wire logic [31:0] energy_in, // live energy accumulation
  output logic [31:0] energy_out, // energy on its refresh schedule
  output logic [23:0] good_sample_out, // last sample that passed CRC
  output logic int_pin_first_n_out, // interrupt pin, active low
  output logic int_pin_second_n_out, // interrupt pin, active low
  output logic int_pin_third_n_out, // interrupt pin, active low
  output logic int_pin_fourth_n_out // interrupt pin, active low
);
  import isa_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [15:0] ms_cnt;
    logic booted;
    logic [3:0][31:0] enable;
    logic [31:0] fault_enable;
    logic energy_timer_sel;
    logic in_half_dip;
    logic in_one_dip;
    logic in_half_swell;
    logic in_one_swell;
    logic [23:0] half_dip_min;
    logic [23:0] one_dip_min;
    logic [23:0] half_swell_max;
    logic [23:0] one_swell_max;
    logic [31:0] meas;
    logic [31:0] energy;
    logic [23:0] good_sample;
    logic [31:0] rdata;
    logic [3:0] pin_n;
  } isa_st_t;

  isa_st_t state_ff;
  isa_st_t nxt_state;

  logic [4:0][31:0] set_vec;
  logic [4:0][31:0] clr_vec;
  logic [4:0][31:0] flags;
  logic [31:0] second_view;
  logic [31:0] conv_fault;
  logic fault_summary;
  logic ms_tick;
  logic energy_refresh;
  logic [3:0][31:0] pending;

  // ==========================================================================
  // min/max tracking: restart at event onset, then keep the extreme
  function automatic logic [23:0] track(input logic want_max, input logic was_in,
                                        input logic [23:0] cur, input logic [23:0] val);
    logic [23:0] res;
    res = cur;
    if (!was_in) begin
      res = val;
    end else if (want_max ? (val > cur) : (val < cur)) begin
      res = val;
    end
    return res;
  endfunction

  // ==========================================================================
  // cadence
  assign ms_tick = (state_ff.ms_cnt == 16'(REFRESH_CYCLES - 1));
  assign energy_refresh = state_ff.energy_timer_sel ? dp_in.energy_line_stb : ms_tick;

  // ==========================================================================
  // converter status folding, one fault bit per converter status register
  always_comb begin
    conv_fault = ZERO_WORD;
    for (int c = 0; c < 4; c++) begin
      // level condition: the bit keeps setting until the converter copy clears
      conv_fault[BIT_CONV_BASE + c * 3 + 0] = |(conv_stat_in[c][0] & CONV_SEL_FIRST);
      conv_fault[BIT_CONV_BASE + c * 3 + 1] = |(conv_stat_in[c][1] & CONV_SEL_SECOND);
      conv_fault[BIT_CONV_BASE + c * 3 + 2] = |(conv_stat_in[c][2] & CONV_SEL_THIRD);
    end
  end

  assign fault_summary = |(flags[4] & state_ff.fault_enable);

  // ==========================================================================
  // event sources for each sticky register
  always_comb begin
    set_vec = '0;
    set_vec[0] = dp_in.shared_evt;
    set_vec[0][BIT_SHARED_14] = !state_ff.booted;
    set_vec[0][BIT_ENERGY_READY] = dp_in.shared_evt[BIT_ENERGY_READY] | energy_refresh;
    set_vec[1] = dp_in.shared_evt;
    set_vec[1][BIT_SHARED_14] = 1'b0;
    set_vec[1][BIT_ENERGY_READY] = set_vec[0][BIT_ENERGY_READY];
    set_vec[2] = dp_in.third_evt;
    set_vec[2][BIT_DIP_EVT] = dp_in.third_evt[BIT_DIP_EVT] | (dp_in.one_stb & dp_in.dip_one);
    set_vec[2][BIT_SWELL_EVT] = dp_in.third_evt[BIT_SWELL_EVT]
                                | (dp_in.one_stb & dp_in.swell_one);
    set_vec[3] = dp_in.fourth_evt;
    set_vec[3][BIT_DIP_EVT] = dp_in.fourth_evt[BIT_DIP_EVT]
                              | (dp_in.half_stb & dp_in.dip_half);
    set_vec[3][BIT_SWELL_EVT] = dp_in.fourth_evt[BIT_SWELL_EVT]
                                | (dp_in.half_stb & dp_in.swell_half);
    set_vec[4] = conv_fault;
    set_vec[4][BIT_INIT_FAIL] = dp_in.init_fail;
    set_vec[4][5:1] = dp_in.internal_fault[4:0];
    set_vec[4][7] = dp_in.internal_fault[5];
    set_vec[4][BIT_CRC_FAIL] = dp_in.sample_stb & dp_in.crc_fail;
    set_vec[4][BIT_RATE_FAULT] = dp_in.rate_fault;
  end

  // ==========================================================================
  // five sticky registers
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flags
      assign clr_vec[gi] = (reg_req_in.wr && reg_req_in.addr == 4'(gi)) ? reg_req_in.wdata
                                                                       : ZERO_WORD;
      isa_w1c_reg u_flags (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .set_in(set_vec[gi]),
        .clr_in(clr_vec[gi]),
        .flags_out(flags[gi])
      );
    end
  endgenerate

  // bit 14 of the second register is a live view, so a write to it does nothing
  always_comb begin
    second_view = flags[1];
    second_view[BIT_SHARED_14] = fault_summary;
  end

  always_comb begin
    pending[0] = flags[0] & (state_ff.enable[0] | ENABLE_SECOND_RESET);
    pending[1] = second_view & state_ff.enable[1];
    pending[2] = flags[2] & state_ff.enable[2];
    pending[3] = flags[3] & state_ff.enable[3];
  end

  // ==========================================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.booted = 1'b1;
    nxt_state.ms_cnt = ms_tick ? 16'h0000 : state_ff.ms_cnt + 16'h0001;
    if (ms_tick) begin
      nxt_state.meas = meas_in;
    end
    if (energy_refresh) begin
      nxt_state.energy = energy_in;
    end
    // a failed sample is dropped and the previous good one stays in use
    if (dp_in.sample_stb && !dp_in.crc_fail) begin
      nxt_state.good_sample = dp_in.sample;
    end
    if (dp_in.half_stb) begin
      nxt_state.in_half_dip = dp_in.dip_half;
      nxt_state.in_half_swell = dp_in.swell_half;
      if (dp_in.dip_half) begin
        nxt_state.half_dip_min = track(1'b0, state_ff.in_half_dip, state_ff.half_dip_min,
                                       dp_in.rms_half);
      end
      if (dp_in.swell_half) begin
        nxt_state.half_swell_max = track(1'b1, state_ff.in_half_swell,
                                         state_ff.half_swell_max, dp_in.rms_half);
      end
    end
    if (dp_in.one_stb) begin
      nxt_state.in_one_dip = dp_in.dip_one;
      nxt_state.in_one_swell = dp_in.swell_one;
      if (dp_in.dip_one) begin
        nxt_state.one_dip_min = track(1'b0, state_ff.in_one_dip, state_ff.one_dip_min,
                                      dp_in.rms_one);
      end
      if (dp_in.swell_one) begin
        nxt_state.one_swell_max = track(1'b1, state_ff.in_one_swell, state_ff.one_swell_max,
                                        dp_in.rms_one);
      end
    end
    if (reg_req_in.wr) begin
      if (reg_req_in.addr >= IDX_ENABLE_FIRST && reg_req_in.addr < IDX_FAULT_ENABLE) begin
        nxt_state.enable[2'(reg_req_in.addr - IDX_ENABLE_FIRST)] = reg_req_in.wdata;
      end
      if (reg_req_in.addr == IDX_FAULT_ENABLE) begin
        nxt_state.fault_enable = reg_req_in.wdata;
      end
      if (reg_req_in.addr == IDX_ENERGY_PULSE_CFG) begin
        nxt_state.energy_timer_sel = reg_req_in.wdata[BIT_ENERGY_TIMER_SEL];
      end
    end
    unique case (reg_req_in.addr)
      IDX_FLAGS_FIRST: nxt_state.rdata = flags[0];
      IDX_FLAGS_SECOND: nxt_state.rdata = second_view;
      IDX_FLAGS_THIRD: nxt_state.rdata = flags[2];
      IDX_FLAGS_FOURTH: nxt_state.rdata = flags[3];
      IDX_FAULT_FLAGS: nxt_state.rdata = flags[4];
      4'h5, 4'h6, 4'h7, 4'h8: nxt_state.rdata = state_ff.enable[2'(reg_req_in.addr - 4'h5)];
      IDX_FAULT_ENABLE: nxt_state.rdata = state_ff.fault_enable;
      IDX_ENERGY_PULSE_CFG: nxt_state.rdata = {31'h0000_0000, state_ff.energy_timer_sel};
      IDX_HALF_DIP_MIN: nxt_state.rdata = {8'h00, state_ff.half_dip_min};
      IDX_ONE_DIP_MIN: nxt_state.rdata = {8'h00, state_ff.one_dip_min};
      IDX_HALF_SWELL_MAX: nxt_state.rdata = {8'h00, state_ff.half_swell_max};
      IDX_ONE_SWELL_MAX: nxt_state.rdata = {8'h00, state_ff.one_swell_max};
      default: nxt_state.rdata = ZERO_WORD;
    endcase
    // pins fall one edge after a flag and enable coincide
    for (int p = 0; p < 4; p++) begin
      nxt_state.pin_n[p] = ~|pending[p];
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= '0;
      state_ff.enable[1] <= ENABLE_SECOND_RESET;
      state_ff.pin_n <= 4'hF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_out = state_ff.rdata;
  assign meas_out = state_ff.meas;
  assign energy_out = state_ff.energy;
  assign good_sample_out = state_ff.good_sample;
  assign int_pin_first_n_out = state_ff.pin_n[0];
  assign int_pin_second_n_out = state_ff.pin_n[1];
  assign int_pin_third_n_out = state_ff.pin_n[2];
  assign int_pin_fourth_n_out = state_ff.pin_n[3];

  // ==========================================================================
  // checks
  sequence s_refresh;
    ms_tick ##1 (meas_out == $past(meas_in));
  endsequence

  a_ms_refresh: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ms_tick |-> s_refresh) else $error("measurement not refreshed on tick");

  a_ms_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !ms_tick |=> $stable(meas_out)) else $error("measurement changed off tick");

  a_energy_ready: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    energy_refresh |=> flags[0][BIT_ENERGY_READY] && flags[1][BIT_ENERGY_READY]
                       && energy_out == $past(energy_in)) else $error("energy refresh lost");

  a_dip_half_min: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (dp_in.half_stb && dp_in.dip_half) |=> state_ff.half_dip_min <= $past(dp_in.rms_half)
      && flags[3][BIT_DIP_EVT]) else $error("half dip minimum wrong");

  a_dip_one_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(dp_in.one_stb && dp_in.dip_one) |=> $stable(state_ff.one_dip_min))
    else $error("one dip minimum moved outside dip");

  a_swell_half_max: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (dp_in.half_stb && dp_in.swell_half) |=> state_ff.half_swell_max >= $past(dp_in.rms_half))
    else $error("half swell maximum too small");

  a_swell_one_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (dp_in.one_stb && dp_in.swell_one) |=> flags[2][BIT_SWELL_EVT]
      && state_ff.one_swell_max >= $past(dp_in.rms_one)) else $error("one swell lost");

  a_pin_pending: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (|(flags[2] & state_ff.enable[2])) |=> !int_pin_third_n_out)
    else $error("third pin not low with enabled flag");

  a_pin_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (pending[3] == ZERO_WORD) |=> int_pin_fourth_n_out)
    else $error("fourth pin low with nothing pending");

  a_reset_complete_flag_unmask: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    flags[0][BIT_SHARED_14] |=> !int_pin_first_n_out)
    else $error("reset complete did not drive first pin");

  a_fault_route: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (|(flags[4] & state_ff.fault_enable)) && state_ff.enable[1][BIT_SHARED_14]
      |=> !int_pin_second_n_out) else $error("enabled fault missed second pin");

  a_conv_reassert: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (|(conv_stat_in[2][1] & CONV_SEL_SECOND)) |=> flags[4][BIT_CONV_BASE + 7])
    else $error("converter fault not held");

  a_crc_keep: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (dp_in.sample_stb && dp_in.crc_fail) |=> $stable(good_sample_out)
      && flags[4][BIT_CRC_FAIL]) else $error("bad sample used");

  a_set_wins: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (dp_in.rate_fault && clr_vec[4][BIT_RATE_FAULT]) |=> flags[4][BIT_RATE_FAULT])
    else $error("clear beat a concurrent event");

endmodule
`default_nettype wire

// >>> dv/isa_host_model.sv
// host-side model that watches the four interrupt pins
`timescale 1ns/1ps
`default_nettype none

module isa_host_model (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_in, // async reset, active high
  input wire logic [3:0] pin_n_in, // interrupt pins, active low
  output logic [3:0] low_seen_out // pins seen asserted since reset
);
  // ==========================================================================
  // pin watch
  // a polling host sees levels, not edges, so a pin held low counts once
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_seen_out <= 4'h0;
    end else begin
      low_seen_out <= low_seen_out | ~pin_n_in;
    end
  end
endmodule

`default_nettype wire

// >>> dv/test_isa_status_top.sv
// self-checking testbench of the status and interrupt aggregator
`timescale 1ns/1ps
`default_nettype none

module test_isa_status_top;
  import isa_pkg::*;
  localparam int unsigned RC = 20;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  isa_reg_req_t req = '0;
  isa_dp_in_t dp = '0;
  isa_conv_stat_t conv = '0;
  logic [31:0] meas = 32'h0000_0000;
  logic [31:0] egy = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] meas_q;
  logic [31:0] egy_q;
  logic [23:0] good;
  logic [3:0] pin_n;
  logic [3:0] seen;
  logic [31:0] v;
  int bad_count = 0;
  int n_compared = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  isa_status_top #(.REFRESH_CYCLES(RC)) uut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .dp_in(dp), .conv_stat_in(conv), .meas_in(meas),
    .meas_out(meas_q), .energy_in(egy), .energy_out(egy_q), .good_sample_out(good),
    .int_pin_first_n_out(pin_n[0]), .int_pin_second_n_out(pin_n[1]),
    .int_pin_third_n_out(pin_n[2]), .int_pin_fourth_n_out(pin_n[3]));

  isa_host_model host (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .pin_n_in(pin_n),
    .low_seen_out(seen));

  // ==========================================================================
  // access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
  endtask

  // read data lags the address by one edge; two edges leave margin
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    req.addr <= a;
    repeat (2) @(posedge sys_clk_in);
    #1 v = rdata;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================================
  // test sequence
  initial begin
    logic [7:0] sel [3];
    logic [23:0] dv [3];
    logic [23:0] sv [3];
    sel = '{CONV_SEL_FIRST, CONV_SEL_SECOND, CONV_SEL_THIRD};
    dv = '{24'h00_0300, 24'h00_0100, 24'h00_0200};
    sv = '{24'h00_0100, 24'h00_0300, 24'h00_0200};
    repeat (16) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    edges(2);
    chk(pin_n, 4'b1110);
    rd(IDX_FLAGS_FIRST);
    chk(v[14], 1'b1);
    rd(IDX_ENABLE_FIRST + 4'h1);
    chk(v, ENABLE_SECOND_RESET);
    wr(IDX_FLAGS_FIRST, 32'h0000_4000);
    edges(2);
    chk(pin_n[0], 1'b1);
    // event on bit 5, enabled only towards the first pin
    wr(IDX_ENABLE_FIRST, 32'h0000_0020);
    @(posedge sys_clk_in);
    dp.shared_evt <= 32'h0000_0020;
    @(posedge sys_clk_in);
    dp.shared_evt <= '0;
    edges(3);
    chk(pin_n[1:0], 2'b10);
    wr(IDX_FLAGS_FIRST, 32'h0000_0000);
    edges(2);
    chk(pin_n[0], 1'b0);
    @(posedge sys_clk_in);
    req <= '{wr: 1'b1, addr: IDX_FLAGS_FIRST, wdata: 32'h0000_0020};
    dp.shared_evt <= 32'h0000_0020;
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
    dp.shared_evt <= '0;
    edges(2);
    chk(pin_n[0], 1'b0);
    wr(IDX_FLAGS_FIRST, 32'h0000_0020);
    edges(2);
    chk(pin_n[0], 1'b1);
    // rate fault held: summary gated by fault enable, clear refused while held
    @(posedge sys_clk_in);
    dp.rate_fault <= 1'b1;
    rd(IDX_FLAGS_SECOND);
    chk(v[14], 1'b0);
    wr(IDX_FAULT_ENABLE, 32'h0000_0100);
    rd(IDX_FLAGS_SECOND);
    chk(v[14], 1'b1);
    chk(pin_n[1], 1'b0);
    wr(IDX_FAULT_FLAGS, 32'h0000_0100);
    rd(IDX_FAULT_FLAGS);
    chk(v[8], 1'b1);
    @(posedge sys_clk_in);
    dp.rate_fault <= 1'b0;
    wr(IDX_FAULT_FLAGS, 32'h0000_0100);
    rd(IDX_FAULT_FLAGS);
    chk(v[8], 1'b0);
    chk(pin_n[1], 1'b1);
    // good sample, then a corrupted one, with init and internal faults alongside
    @(posedge sys_clk_in);
    dp.sample <= 24'h12_3456;
    dp.sample_stb <= 1'b1;
    @(posedge sys_clk_in);
    dp.sample <= 24'h65_4321;
    dp.crc_fail <= 1'b1;
    dp.init_fail <= 1'b1;
    dp.internal_fault <= 6'h01;
    @(posedge sys_clk_in);
    dp.sample_stb <= 1'b0;
    dp.crc_fail <= 1'b0;
    dp.init_fail <= 1'b0;
    dp.internal_fault <= 6'h00;
    rd(IDX_FAULT_FLAGS);
    chk(good, 24'h12_3456);
    chk(v[6], 1'b1);
    chk(v[1:0], 2'b11);
    // converter 2: unselected bits ignored, clear refused until status cleared
    for (int r = 0; r < 3; r++) begin
      @(posedge sys_clk_in);
      conv[2][r] <= ~sel[r];
      rd(IDX_FAULT_FLAGS);
      chk(v[15 + r], 1'b0);
      @(posedge sys_clk_in);
      conv[2][r] <= sel[r];
      wr(IDX_FAULT_FLAGS, 32'h0000_8000 << r);
      rd(IDX_FAULT_FLAGS);
      chk(v[15 + r], 1'b1);
      @(posedge sys_clk_in);
      conv[2][r] <= 8'h00;
      wr(IDX_FAULT_FLAGS, 32'h0000_8000 << r);
      rd(IDX_FAULT_FLAGS);
      chk(v[15 + r], 1'b0);
    end
    // refresh cadence: millisecond tick, then energy on its own strobe
    @(posedge sys_clk_in);
    meas <= 32'h1234_5678;
    edges(RC + 2);
    chk(meas_q, 32'h1234_5678);
    wr(IDX_ENERGY_PULSE_CFG, 32'h0000_0001);
    wr(IDX_FLAGS_FIRST, 32'hFFFF_FFFF);
    egy <= 32'h0BAD_F00D;
    edges(RC + 2);
    rd(IDX_FLAGS_FIRST);
    chk(v[0], 1'b0);
    chk(egy_q, 32'h0000_0000);
    @(posedge sys_clk_in);
    dp.energy_line_stb <= 1'b1;
    @(posedge sys_clk_in);
    dp.energy_line_stb <= 1'b0;
    rd(IDX_FLAGS_FIRST);
    chk(egy_q, 32'h0BAD_F00D);
    chk(v[0], 1'b1);
    // all four trackers over three strobes; third pin on dip, fourth pin on swell
    wr(IDX_ENABLE_FIRST + 4'h2, 32'h0000_0001);
    wr(IDX_ENABLE_FIRST + 4'h3, 32'h0000_0002);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_in);
      dp.rms_one <= dv[i];
      dp.rms_half <= sv[i];
      dp.one_stb <= 1'b1;
      dp.half_stb <= 1'b1;
      dp.dip_one <= 1'b1;
      dp.swell_one <= 1'b1;
      dp.dip_half <= 1'b1;
      dp.swell_half <= 1'b1;
      @(posedge sys_clk_in);
      dp.one_stb <= 1'b0;
      dp.half_stb <= 1'b0;
    end
    dp.dip_one <= 1'b0;
    dp.swell_one <= 1'b0;
    dp.dip_half <= 1'b0;
    dp.swell_half <= 1'b0;
    rd(IDX_ONE_DIP_MIN);
    chk(v, 32'h0000_0100);
    rd(IDX_HALF_SWELL_MAX);
    chk(v, 32'h0000_0300);
    rd(IDX_HALF_DIP_MIN);
    chk(v, 32'h0000_0100);
    rd(IDX_ONE_SWELL_MAX);
    chk(v, 32'h0000_0300);
    rd(IDX_FLAGS_THIRD);
    chk(v[0], 1'b1);
    chk(v[1], 1'b1);
    rd(IDX_FLAGS_FOURTH);
    chk(v[0], 1'b1);
    chk(v[1], 1'b1);
    chk(pin_n[3:2], 2'b00);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF);
    chk(v, ZERO_WORD);
    chk(seen, 4'b1111);
    // host answers the internal fault with a device reset
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    edges(2);
    chk(pin_n, 4'b1111);
    @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(IDX_FAULT_FLAGS);
    chk(v, ZERO_WORD);
    rd(IDX_ENABLE_FIRST + 4'h1);
    chk(v, ENABLE_SECOND_RESET);
    tally_and_finish();
  end
endmodule

`default_nettype wire
